// ===== verilog/dcfp_port_flags.sv
// fifo pair with port qualification, output registers and status flags
// assumes port masters run on core_clk_i and keep their own handshake
//
// Summary of operation
// - b-to-a near-empty flag high only above the empty offset count
// - near-full low at depth minus full offset; full low only at depth
// - output register word not counted; its memory slot is freed
// - port b data driven only when selected and direction high
// - b write needs select, direction low, enable, no mail, input ready
// - b read needs select, direction high, enable, no mail, output ready
// - fall-through loads next word on the edge raising output ready
// - with output ready high, new words load only on a selected read
// - standard mode: empty flag rises on second edge, no auto load
// - mode picks output/input ready or empty/full meaning of flags
// - flags cross through at least two flip-flop stages
// - each port's flags are generated on that port's clock
// - output ready high means new word; low holds word, ignores reads
// - empty high means word to read; low holds word, ignores reads
// - read pointer steps once per word loaded to output register
// - fall-through word reaches output on third edge after write
// - standard empty flag rises on second edge after head write
// - sync cycle starts only after the skew window from the event
// - input ready high means free slot; low ignores writes
// - write pointer steps once per accepted word
// - full flag rises on second edge after a read frees a slot
// - a read needs select, direction low, enable, no mail, output ready
`timescale 1ns/1ps

// ************************************************************
// one direction: memory, pointers, flags
// ************************************************************
module dcfp_fifo #(
    parameter  int WIDTH = dcfp_pkg::DATA_W,
    parameter  int DEPTH = dcfp_pkg::BUF_DEPTH,
    localparam int AW    = $clog2(DEPTH),
    localparam int CW    = AW + 1
) (
    input  wire logic                    core_clk_i,
    input  wire logic                    rst_n_i,
    input  wire logic                    fall_through_mode_i,
    input  wire logic                    wr_valid_i,
    input  wire logic [WIDTH-1:0]        wr_data_i,
    output logic                         wr_ready_o,
    input  wire logic                    rd_ready_i,
    output logic                         rd_valid_o,
    output logic [WIDTH-1:0]             rd_data_o,
    input  wire logic [CW-1:0]           empty_offset_i,
    input  wire logic [CW-1:0]           full_offset_i,
    output dcfp_pkg::dcfp_flags_type     flags_o
);

    logic [CW-1:0]    wptr_q;
    logic [CW-1:0]    rptr_q;
    logic [CW-1:0]    wptr_s1_q;
    logic [CW-1:0]    wptr_s2_q;
    logic [CW-1:0]    rptr_s1_q;
    logic [CW-1:0]    rptr_s2_q;
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [WIDTH-1:0] dout_q;
    logic             or_q;

    // ************************************************************
    // occupancy as seen from each side
    // ************************************************************
    // counts exclude the output register
    wire [CW-1:0] rd_count  = wptr_s2_q - rptr_q;
    // freed slot seen after two edges
    wire [CW-1:0] wr_count  = wptr_q - rptr_s2_q;
    wire          mem_has   = (rd_count != '0);
    wire          full_w    = (wr_count == CW'(DEPTH));
    // offsets above depth wrap the threshold; keep them in range
    // threshold from depth and offset
    wire [CW-1:0] af_level  = CW'(DEPTH) - full_offset_i;

    wire          wr_ok     = wr_valid_i && !full_w;
    // auto load when output ready low
    // with output ready high only a read loads
    wire          ft_load   = mem_has && (!or_q || rd_ready_i);
    // standard mode loads on read only
    wire          std_load  = mem_has && rd_ready_i;
    wire          load      = fall_through_mode_i ? ft_load : std_load;
    wire          or_clr    = fall_through_mode_i && or_q && rd_ready_i && !mem_has;

    // ************************************************************
    // flags
    // ************************************************************
    // flag meaning follows mode
    // standard flag is memory not empty
    assign rd_valid_o = fall_through_mode_i ? or_q : mem_has;
    assign wr_ready_o = !full_w;
    assign rd_data_o  = dout_q;
    assign flags_o.near_empty_n       = (rd_count > empty_offset_i);
    assign flags_o.near_full_n        = (wr_count < af_level);
    assign flags_o.empty_or_out_ready = rd_valid_o;
    assign flags_o.full_or_in_ready   = wr_ready_o;

    // ************************************************************
    // pointers and crossings
    // ************************************************************
    // write pointer step
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wptr_q <= '0;
        end else if (wr_ok) begin
            wptr_q <= wptr_q + CW'(1);
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rptr_q <= '0;
        end else if (load) begin
            rptr_q <= rptr_q + CW'(1);
        end
    end

    // head write reaches the reader after two edges
    // single clock here, so the skew window adds no cycle
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wptr_s1_q <= '0;
            wptr_s2_q <= '0;
            rptr_s1_q <= '0;
            rptr_s2_q <= '0;
        end else begin
            wptr_s1_q <= wptr_q;
            wptr_s2_q <= wptr_s1_q;
            rptr_s1_q <= rptr_q;
            rptr_s2_q <= rptr_s1_q;
        end
    end

    // storage has no reset; unread slots never reach the output
    always_ff @(posedge core_clk_i) begin
        if (wr_ok) begin
            mem_q[wptr_q[AW-1:0]] <= wr_data_i;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dout_q <= '0;
        end else if (load) begin
            dout_q <= mem_q[rptr_q[AW-1:0]];
        end
    end

    // output ready rises with the load
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            or_q <= 1'b0;
        end else if (fall_through_mode_i && load) begin
            or_q <= 1'b1;
        end else if (or_clr) begin
            or_q <= 1'b0;
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    wire idle_w = (wptr_s1_q == wptr_q) && (wptr_s2_q == wptr_q) && (rd_count == '0);

    chk_full_ignores: assert property (
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (wr_valid_i && !wr_ready_o) |=> $stable(wptr_q))
        else $error("write taken while full");

    chk_wptr_step: assert property (
        @(posedge core_clk_i) disable iff (!rst_n_i)
        wr_ok |=> (wptr_q == $past(wptr_q) + CW'(1)))
        else $error("write pointer did not step");

    chk_rptr_load: assert property (
        @(posedge core_clk_i) disable iff (!rst_n_i)
        load |=> (rptr_q == $past(rptr_q) + CW'(1)) && $changed(rptr_q))
        else $error("read pointer did not follow load");

    chk_empty_hold: assert property (
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (!fall_through_mode_i && rd_ready_i && !rd_valid_o) |=> $stable(dout_q) && $stable(rptr_q))
        else $error("read taken while empty");

    chk_or_hold: assert property (
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (fall_through_mode_i && !or_q && !mem_has) |=> $stable(dout_q) && !or_q)
        else $error("output register changed without word");

    chk_ft_third_edge: assert property (
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (fall_through_mode_i && wr_ok && idle_w && !or_q)
            |-> ##1 !rd_valid_o [*3] ##1 rd_valid_o)
        else $error("fall-through word not ready on third edge");

    chk_std_second_edge: assert property (
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (!fall_through_mode_i && wr_ok && idle_w)
            |-> ##1 !rd_valid_o [*2] ##1 rd_valid_o)
        else $error("empty flag not raised on second edge");

    chk_free_second_edge: assert property (
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (full_w && load && rptr_s1_q == rptr_q && rptr_s2_q == rptr_q)
            |-> ##1 !wr_ready_o [*2] ##1 wr_ready_o)
        else $error("input ready not raised on second edge");

    chk_near_full_lvl: assert property (
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (wr_count >= af_level) |-> !flags_o.near_full_n)
        else $error("near-full high at threshold");

    chk_full_near: assert property (
        @(posedge core_clk_i) disable iff (!rst_n_i)
        !wr_ready_o |-> !flags_o.near_full_n)
        else $error("full without near-full");

    chk_near_empty_lvl: assert property (
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (rd_count <= empty_offset_i) |-> !flags_o.near_empty_n)
        else $error("near-empty high at or below offset");

    chk_ft_auto_load: assert property (
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (fall_through_mode_i && !or_q && mem_has) |=> or_q && (rptr_q == $past(rptr_q) + CW'(1)))
        else $error("fall-through head word not loaded");

    chk_ft_read_only: assert property (
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (fall_through_mode_i && or_q && !rd_ready_i) |=> $stable(rptr_q) && $stable(dout_q))
        else $error("output register loaded without a read");

    chk_std_no_ready: assert property (
        @(posedge core_clk_i) disable iff (!rst_n_i)
        !fall_through_mode_i |-> !or_q)
        else $error("output ready set in standard mode");

endmodule

// ************************************************************
// port qualification and the two directions
// ************************************************************
module dcfp_port_flags #(
    parameter  int DEPTH = dcfp_pkg::DEPTH_SMALL,
    localparam int CW    = $clog2(DEPTH) + 1
) (
    input  wire logic                        core_clk_i,
    input  wire logic                        rst_n_i,
    input  wire logic                        fall_through_mode_i,
    input  wire logic [CW-1:0]               fifo1_empty_offset_i,
    input  wire logic [CW-1:0]               fifo1_full_offset_i,
    input  wire logic [CW-1:0]               fifo2_empty_offset_i,
    input  wire logic [CW-1:0]               fifo2_full_offset_i,
    input  wire logic                        port_a_select_n_i,
    input  wire logic                        port_a_direction_i,
    input  wire logic                        port_a_transfer_en_i,
    input  wire logic                        port_a_mail_sel_i,
    input  wire logic [dcfp_pkg::DATA_W-1:0] port_a_data_i,
    output logic      [dcfp_pkg::DATA_W-1:0] port_a_data_o,
    output logic                             port_a_data_oe_o,
    output logic                             a_empty_or_out_ready_o,
    output logic                             a_near_empty_n_o,
    output logic                             a_near_full_n_o,
    output logic                             a_full_or_in_ready_o,
    input  wire logic                        port_b_select_n_i,
    input  wire logic                        port_b_direction_i,
    input  wire logic                        port_b_transfer_en_i,
    input  wire logic                        port_b_mail_sel_i,
    input  wire logic [dcfp_pkg::DATA_W-1:0] port_b_data_i,
    output logic      [dcfp_pkg::DATA_W-1:0] port_b_data_o,
    output logic                             port_b_data_oe_o,
    output logic                             b_empty_or_out_ready_o,
    output logic                             b_near_empty_n_o,
    output logic                             b_near_full_n_o,
    output logic                             b_full_or_in_ready_o
);

    dcfp_pkg::dcfp_ctrl_type  ctl_a;
    dcfp_pkg::dcfp_ctrl_type  ctl_b;
    dcfp_pkg::dcfp_flags_type fl1;
    dcfp_pkg::dcfp_flags_type fl2;

    assign ctl_a = '{port_a_select_n_i, port_a_direction_i,
                     port_a_transfer_en_i, port_a_mail_sel_i};
    assign ctl_b = '{port_b_select_n_i, port_b_direction_i,
                     port_b_transfer_en_i, port_b_mail_sel_i};

    // for transfers, select and direction only matter with enable high; the data output enables ignore enable
    wire a_go     = !ctl_a.select_n && ctl_a.transfer_en && !ctl_a.mail_sel;
    wire b_go     = !ctl_b.select_n && ctl_b.transfer_en && !ctl_b.mail_sel;
    wire a_wr_sel = a_go && ctl_a.direction;
    wire a_rd_sel = a_go && !ctl_a.direction;
    wire b_wr_sel = b_go && !ctl_b.direction;
    wire b_rd_sel = b_go && ctl_b.direction;

    // b drivers on select with direction high
    assign port_b_data_oe_o = !ctl_b.select_n && ctl_b.direction;
    assign port_a_data_oe_o = !ctl_a.select_n && !ctl_a.direction;

    // ************************************************************
    // a to b direction
    // ************************************************************
    // a-side flags from the write side, b-side from the read side
    dcfp_fifo #(
        .WIDTH (dcfp_pkg::DATA_W),
        .DEPTH (DEPTH)
    ) u_fifo1 (
        .core_clk_i          (core_clk_i),
        .rst_n_i             (rst_n_i),
        .fall_through_mode_i (fall_through_mode_i),
        .wr_valid_i          (a_wr_sel),
        .wr_data_i           (port_a_data_i),
        .wr_ready_o          (a_full_or_in_ready_o),
        .rd_ready_i          (b_rd_sel),
        .rd_valid_o          (b_empty_or_out_ready_o),
        .rd_data_o           (port_b_data_o),
        .empty_offset_i      (fifo1_empty_offset_i),
        .full_offset_i       (fifo1_full_offset_i),
        .flags_o             (fl1)
    );

    // ************************************************************
    // b to a direction
    // ************************************************************
    dcfp_fifo #(
        .WIDTH (dcfp_pkg::DATA_W),
        .DEPTH (DEPTH)
    ) u_fifo2 (
        .core_clk_i          (core_clk_i),
        .rst_n_i             (rst_n_i),
        .fall_through_mode_i (fall_through_mode_i),
        .wr_valid_i          (b_wr_sel),
        .wr_data_i           (port_b_data_i),
        .wr_ready_o          (b_full_or_in_ready_o),
        .rd_ready_i          (a_rd_sel),
        .rd_valid_o          (a_empty_or_out_ready_o),
        .rd_data_o           (port_a_data_o),
        .empty_offset_i      (fifo2_empty_offset_i),
        .full_offset_i       (fifo2_full_offset_i),
        .flags_o             (fl2)
    );

    assign b_near_empty_n_o = fl1.near_empty_n;
    assign a_near_full_n_o  = fl1.near_full_n;
    assign a_near_empty_n_o = fl2.near_empty_n;
    assign b_near_full_n_o  = fl2.near_full_n;

    chk_b_drive: assert property (
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (port_b_select_n_i || !port_b_direction_i) |-> !port_b_data_oe_o)
        else $error("port b driven while deselected or writing");

    chk_b_write_qual: assert property (
        @(posedge core_clk_i) disable iff (!rst_n_i)
        !(b_wr_sel && b_full_or_in_ready_o) |=> $stable(u_fifo2.wptr_q))
        else $error("port b write taken without qualification");

    chk_b_read_qual: assert property (
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (b_empty_or_out_ready_o && !b_rd_sel) |=> $stable(u_fifo1.rptr_q))
        else $error("port b read taken without qualification");

    chk_a_read_qual: assert property (
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (a_empty_or_out_ready_o && !a_rd_sel) |=> $stable(u_fifo2.rptr_q))
        else $error("port a read taken without qualification");

endmodule

// ===== inc/dcfp_pkg.sv
// constants and carrier types of the bidirectional fifo port-flag block
// assumes one clock drives both ports and their external masters
package dcfp_pkg;

    // ************************************************************
    // sizes
    // ************************************************************
    localparam int DATA_W      = 36;
    localparam int DEPTH_SMALL = 2048;
    localparam int DEPTH_MID   = 4096;
    localparam int DEPTH_LARGE = 8192;
    localparam int BUF_DEPTH   = 16;
    localparam int SYNC_STAGES = 2;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int CLK_PERIOD_PS        = 5000;
    // skew window in ps; zero because both ports share one clock
    localparam int SYNC_SKEW_WINDOW_PS  = 0;
    localparam int SYNC_SKEW_CYCLES     =
        (SYNC_SKEW_WINDOW_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // ************************************************************
    // carriers
    // ************************************************************
    typedef struct packed {
        logic empty_or_out_ready;
        logic near_empty_n;
        logic near_full_n;
        logic full_or_in_ready;
    } dcfp_flags_type;

    typedef struct packed {
        logic select_n;
        logic direction;
        logic transfer_en;
        logic mail_sel;
    } dcfp_ctrl_type;

endpackage

// ===== sim/dcfp_port_master.sv
// port master model: drives one port's qualifiers and write data
// assumes the bench calls its tasks just after a rising clock edge
`timescale 1ns/1ps

module dcfp_port_master (
    output logic                        select_n_o,
    output logic                        direction_o,
    output logic                        transfer_en_o,
    output logic                        mail_sel_o,
    output logic [dcfp_pkg::DATA_W-1:0] data_o
);
    // ********************
    // request and release
    // ********************
    initial begin
        select_n_o    = 1'b1;
        direction_o   = 1'b0;
        transfer_en_o = 1'b0;
        mail_sel_o    = 1'b0;
        data_o        = '0;
    end

    task automatic drive(input logic sn, input logic dir, input logic en, input logic mb,
                         input logic [dcfp_pkg::DATA_W-1:0] d);
        select_n_o    = sn;
        direction_o   = dir;
        transfer_en_o = en;
        mail_sel_o    = mb;
        data_o        = d;
    endtask

    // qualifiers wander, enable low
    // released data is inverted so a stale word never passes
    task automatic idle();
        transfer_en_o = 1'b0;
        select_n_o    = ~select_n_o;
        direction_o   = ~direction_o;
        mail_sel_o    = ~mail_sel_o;
        data_o        = ~data_o;
    endtask
endmodule

// ===== sim/test_dcfp_port_flags.sv
// self-checking bench of the fifo pair port flags
// assumes both port masters share core_clk_i with the design
`timescale 1ns/1ps

module test_dcfp_port_flags;
    localparam int DEP = dcfp_pkg::DEPTH_SMALL;
    localparam int CW  = $clog2(DEP) + 1;
    localparam int DW  = dcfp_pkg::DATA_W;

    logic            core_clk_i;
    logic            rst_n_i;
    logic            ft;
    logic [CW-1:0]   e1, f1, e2, f2;
    int              error_cnt;
    int              checked;
    wire logic       a_sn, a_dir, a_en, a_mb, b_sn, b_dir, b_en, b_mb;
    wire logic       a_oe, a_eor, a_ne_n, a_nf_n, a_fir;
    wire logic       b_oe, b_eor, b_ne_n, b_nf_n, b_fir;
    wire logic [DW-1:0] a_din, a_dout, b_din, b_dout;

    // ********************
    // masters and block
    // ********************
    dcfp_port_master ma (.select_n_o(a_sn), .direction_o(a_dir), .transfer_en_o(a_en),
        .mail_sel_o(a_mb), .data_o(a_din));
    dcfp_port_master mb (.select_n_o(b_sn), .direction_o(b_dir), .transfer_en_o(b_en),
        .mail_sel_o(b_mb), .data_o(b_din));
    dcfp_port_flags #(.DEPTH(DEP)) uut (
        .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .fall_through_mode_i(ft),
        .fifo1_empty_offset_i(e1), .fifo1_full_offset_i(f1),
        .fifo2_empty_offset_i(e2), .fifo2_full_offset_i(f2),
        .port_a_select_n_i(a_sn), .port_a_direction_i(a_dir),
        .port_a_transfer_en_i(a_en), .port_a_mail_sel_i(a_mb),
        .port_a_data_i(a_din), .port_a_data_o(a_dout), .port_a_data_oe_o(a_oe),
        .a_empty_or_out_ready_o(a_eor), .a_near_empty_n_o(a_ne_n),
        .a_near_full_n_o(a_nf_n), .a_full_or_in_ready_o(a_fir),
        .port_b_select_n_i(b_sn), .port_b_direction_i(b_dir),
        .port_b_transfer_en_i(b_en), .port_b_mail_sel_i(b_mb),
        .port_b_data_i(b_din), .port_b_data_o(b_dout), .port_b_data_oe_o(b_oe),
        .b_empty_or_out_ready_o(b_eor), .b_near_empty_n_o(b_ne_n),
        .b_near_full_n_o(b_nf_n), .b_full_or_in_ready_o(b_fir));

    // ********************
    // helpers
    // ********************
    initial begin
        core_clk_i = 1'b0;
        forever #2.5 core_clk_i = ~core_clk_i;
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk_i);
        #1;
    endtask

    task automatic chk(input logic [DW-1:0] seen, input logic [DW-1:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %0t mismatch seen %h exp %h", $time, seen, exp);
        end
    endtask

    task automatic chkb(input logic seen, input logic exp);
        chk({35'h0, seen}, {35'h0, exp});
    endtask

    task automatic do_reset(input logic mode);
        ft = mode;
        rst_n_i = 1'b0;
        cyc(20);
        rst_n_i = 1'b1;
    endtask

    task automatic wr_b(input logic [DW-1:0] d);
        mb.drive(1'b0, 1'b0, 1'b1, 1'b0, d);
        cyc(1);
    endtask

    task automatic summarize();
        $display("errors %0d checks %0d", error_cnt, checked);
        if (error_cnt == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // ********************
    // scenarios
    // ********************
    task automatic t_reset_oe();
        do_reset(1'b0);
        chkb(b_eor, 1'b0);
        chkb(b_fir, 1'b1);
        chkb(a_ne_n, 1'b0);
        chkb(b_nf_n, 1'b1);
        chkb(a_fir, 1'b1);
        chkb(a_nf_n, 1'b1);
        chkb(b_ne_n, 1'b0);
        for (int i = 0; i < 4; i++) begin
            ma.drive(i[1], i[0], 1'b0, 1'b0, '0);
            mb.drive(i[1], i[0], 1'b0, 1'b0, '0);
            cyc(1);
            chkb(b_oe, !i[1] && i[0]);
            chkb(a_oe, !i[1] && !i[0]);
        end
        cyc(1);
    endtask

    // standard mode: read held from cycle 1, taken only once empty flag rises
    task automatic t_std_pass();
        ma.drive(1'b0, 1'b1, 1'b1, 1'b0, 36'h0_0000_0A51);
        cyc(1);
        chkb(a_fir, 1'b1);
        chkb(a_nf_n, 1'b1);
        ma.idle();
        mb.drive(1'b0, 1'b1, 1'b1, 1'b0, '0);
        chkb(b_eor, 1'b0);
        cyc(1);
        chk(b_dout, '0);
        cyc(1);
        chkb(b_eor, 1'b1);
        chk(b_dout, '0);
        chkb(b_ne_n, 1'b0);
        cyc(1);
        chk(b_dout, 36'h0_0000_0A51);
        chkb(b_eor, 1'b0);
        cyc(1);
        chk(b_dout, 36'h0_0000_0A51);
        mb.idle();
    endtask

    task automatic t_fall_through_mode();
        do_reset(1'b1);
        mb.drive(1'b0, 1'b0, 1'b1, 1'b1, 36'h0_0000_0BAD);
        cyc(1);
        mb.drive(1'b0, 1'b0, 1'b0, 1'b0, 36'h0_0000_0BAD);
        cyc(1);
        mb.idle();
        cyc(4);
        chkb(a_eor, 1'b0);
        wr_b(36'h1);
        mb.idle();
        for (int k = 1; k < 4; k++) begin
            chkb(a_eor, 1'b0);
            cyc(1);
        end
        chkb(a_eor, 1'b1);
        chk(a_dout, 36'h1);
        wr_b(36'h2);
        wr_b(36'h3);
        mb.idle();
        cyc(4);
        chkb(a_ne_n, 1'b0);
        chk(a_dout, 36'h1);
        wr_b(36'h4);
        mb.idle();
        cyc(4);
        chkb(a_ne_n, 1'b1);
        ma.drive(1'b0, 1'b0, 1'b1, 1'b0, '0);
        for (int k = 1; k < 4; k++) begin
            cyc(1);
            chk(a_dout, DW'(k + 1));
        end
        cyc(1);
        chkb(a_eor, 1'b0);
        ma.idle();
        cyc(1);
        chk(a_dout, 36'h4);
    endtask

    // fill through port b, refused write, one read, then drain
    task automatic t_full();
        do_reset(1'b0);
        for (int i = 1; i <= DEP; i++) begin
            wr_b(DW'(i));
            chkb(b_nf_n, i < DEP - int'(f2));
            chkb(b_fir, i != DEP);
        end
        wr_b(36'h0_0000_0ABC);
        mb.idle();
        ma.drive(1'b0, 1'b0, 1'b1, 1'b0, '0);
        cyc(1);
        ma.idle();
        chk(a_dout, 36'h1);
        chkb(b_fir, 1'b0);
        cyc(1);
        chkb(b_fir, 1'b0);
        cyc(1);
        chkb(b_fir, 1'b1);
        ma.drive(1'b0, 1'b0, 1'b1, 1'b0, '0);
        cyc(DEP + 8);
        ma.idle();
        chk(a_dout, DW'(DEP));
        chkb(a_eor, 1'b0);
    endtask

    // ********************
    // sequence and watchdog
    // ********************
    initial begin
        error_cnt = 0;
        checked = 0;
        rst_n_i = 1'b0;
        ft = 1'b0;
        e1 = 12'h001;
        f1 = 12'h004;
        e2 = 12'h002;
        f2 = 12'h004;
        t_reset_oe();
        t_std_pass();
        t_fall_through_mode();
        t_full();
        summarize();
    end

    // about five times the expected run
    initial begin
        #100000;
        error_cnt++;
        summarize();
    end
endmodule
